// *** pkg/ldc_consts.svh ***
// Constants for the laser driver control register bank
`ifndef LDC_CONSTS_SVH
`define LDC_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses carried in the three address bits
// ----------------------------------------------------------------
`define LDC_ADDR_CTRL     3'h0
`define LDC_ADDR_MOD      3'h1
`define LDC_ADDR_BIAS     3'h2
`define LDC_ADDR_EQ       3'h3

// ----------------------------------------------------------------
// Control register field positions and reset value
// ----------------------------------------------------------------
`define LDC_BIT_ENA       7
`define LDC_BIT_PDP       6
`define LDC_BIT_PDR       5
`define LDC_BIT_OLS       4
`define LDC_BIT_FDE       3
`define LDC_BIT_MODULATION_RANGE      2
`define LDC_BIT_EQDIS     1
`define LDC_CTRL_MASK     8'hFE
`define LDC_REG_RESET     8'h00

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define LDC_FRAME_BITS    4'hB
`define LDC_ADDR_MSB      10
`define LDC_ADDR_LSB      8

// ----------------------------------------------------------------
// Current scaling; modulation in uA, bias in 0.5 uA units
// ----------------------------------------------------------------
`define LDC_MOD_STEP_HI   16'h009C
`define LDC_MOD_STEP_LO   16'h004E
`define LDC_COUPLING_RATIO 16'h001E
`define LDC_PD_STEP_LO    16'h0001
`define LDC_PD_STEP_HI    16'h0005
`define LDC_OPEN_STEP     16'h0096
`define LDC_BIAS_CAP      16'h9C40

`endif

// *** pkg/ldc_pkg.sv ***
// Types shared by the laser driver control register bank
package ldc_pkg;

	// Serial receiver states, one-hot
	typedef enum logic [1:0] {
		ldc_rx_idle  = 2'b01,
		ldc_rx_shift = 2'b10
	} ldc_rx_state_type;

endpackage

// *** src/ldc_serial_rx.sv ***
// Write-only two-wire serial frame receiver
`timescale 1ns/1ns
`default_nettype none
`include "ldc_consts.svh"

module ldc_serial_rx (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// Serial pins
	input  wire logic       serial_clk,
	input  wire logic       serial_data,
	// Committed frame
	output var  logic       commit_q,
	output var  logic [2:0] addr_q,
	output var  logic [7:0] data_q
);

	ldc_pkg::ldc_rx_state_type state_q;
	logic        sck_q;
	logic        sda_q;
	logic [10:0] shift_q;
	logic [3:0]  count_q;
	logic        start_det;
	logic        stop_det;
	logic        bit_clk;
	logic        bit_fall;
	logic        bit_pend_q;
	logic        bit_val_q;

	// ------------------------------------------------------------
	// Line condition detection
	// ------------------------------------------------------------

	// Previous pin levels
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sck_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			sck_q <= serial_clk;
			sda_q <= serial_data;
		end
	end

	// Data edges with clock high are start and stop; clock rise is a bit
	assign start_det = serial_clk & sck_q & sda_q & ~serial_data;
	assign stop_det  = serial_clk & sck_q & ~sda_q & serial_data;
	assign bit_clk   = serial_clk & ~sck_q;
	assign bit_fall  = ~serial_clk & sck_q;

	// ------------------------------------------------------------
	// Frame state and shift register
	// ------------------------------------------------------------

	// Start opens a frame from any state, stop closes it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ldc_pkg::ldc_rx_idle;
		end else begin
			case (state_q)
			ldc_pkg::ldc_rx_idle: begin
				if (start_det) begin
					state_q <= ldc_pkg::ldc_rx_shift;
				end
			end
			ldc_pkg::ldc_rx_shift: begin
				if (stop_det) begin
					state_q <= ldc_pkg::ldc_rx_idle;
				end
			end
			default: begin
				state_q <= ldc_pkg::ldc_rx_idle;
			end
			endcase
		end
	end

	// Address then data, MSB first; count saturates at a full frame.
	// A bit is caught as the clock rises and shifted in as it falls, so
	// the clock pulse that leads a stop never enters the frame
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			shift_q    <= 11'h000;
			count_q    <= 4'h0;
			bit_pend_q <= 1'b0;
			bit_val_q  <= 1'b0;
		end else if (start_det) begin
			count_q    <= 4'h0;
			bit_pend_q <= 1'b0;
		end else if (state_q == ldc_pkg::ldc_rx_shift && bit_clk) begin
			bit_pend_q <= 1'b1;
			bit_val_q  <= serial_data;
		end else if (state_q == ldc_pkg::ldc_rx_shift && bit_fall &&
		             bit_pend_q) begin
			bit_pend_q <= 1'b0;
			shift_q    <= {shift_q[9:0], bit_val_q};
			if (count_q != `LDC_FRAME_BITS) begin
				count_q <= count_q + 4'h1;
			end
		end
	end

	// Copy out on stop once a whole frame is in
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			commit_q <= 1'b0;
			addr_q   <= 3'h0;
			data_q   <= 8'h00;
		end else begin
			commit_q <= 1'b0;
			if (state_q == ldc_pkg::ldc_rx_shift && stop_det &&
			    count_q == `LDC_FRAME_BITS) begin
				commit_q <= 1'b1;
				addr_q   <= shift_q[`LDC_ADDR_MSB:`LDC_ADDR_LSB];
				data_q   <= shift_q[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	stop_commit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		commit_q |-> $past(stop_det) &&
		$past(count_q) == `LDC_FRAME_BITS)
		else $error("commit without stop after full frame");

endmodule
`default_nettype wire

// *** src/ldc_ctrl_regs.sv ***
// Laser driver control register bank with setting decode
`timescale 1ns/1ns
`default_nettype none
`include "ldc_consts.svh"

module ldc_ctrl_regs (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Serial pins
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	// Device pins and detector
	input  wire logic        disable_pin,
	input  wire logic        fault_detected,
	output var  logic        fault_flag_pin_q,
	// Decoded settings
	output var  logic        tx_enable_q,
	output var  logic        pd_cathode_vcc_q,
	output var  logic        pd_range_high_q,
	output var  logic        open_loop_select_q,
	output var  logic        fault_detect_enable_q,
	output var  logic        modulation_range_q,
	output var  logic        equalizer_bypass_q,
	output var  logic [7:0]  eq_strength_q,
	output var  logic [15:0] mod_current_ua_q,
	output var  logic [15:0] bias_current_hua_q
);

	logic        rx_commit;
	logic [2:0]  rx_addr;
	logic [7:0]  rx_data;
	logic [7:0]  ctrl_q;
	logic [7:0]  mod_code_q;
	logic [7:0]  bias_code_q;
	logic [7:0]  eq_adjust_q;
	logic        active_d;
	logic        tx_en_d;
	logic [15:0] mod_d;
	logic [15:0] bias_d;
	logic [15:0] closed_mult;

	// Code times step, full width
	function automatic logic [23:0] ldc_scale(input logic [7:0] code,
	                                          input logic [15:0] mult);
		ldc_scale = {16'h0000, code} * {8'h00, mult};
	endfunction

	// Limit a bias product to the bias ceiling
	function automatic logic [15:0] ldc_clamp(input logic [23:0] prod);
		if (prod > {8'h00, `LDC_BIAS_CAP}) begin
			ldc_clamp = `LDC_BIAS_CAP;
		end else begin
			ldc_clamp = prod[15:0];
		end
	endfunction

	// ------------------------------------------------------------
	// Serial receiver
	// ------------------------------------------------------------

	ldc_serial_rx u_rx (
		.clk_sys     (clk_sys),
		.rst_b       (rst_b),
		.serial_clk  (serial_clk),
		.serial_data (serial_data),
		.commit_q    (rx_commit),
		.addr_q      (rx_addr),
		.data_q      (rx_data)
	);

	// ------------------------------------------------------------
	// Register bank
	// ------------------------------------------------------------

	// Only the addressed register loads; unused addresses are ignored
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q      <= `LDC_REG_RESET;
			mod_code_q  <= `LDC_REG_RESET;
			bias_code_q <= `LDC_REG_RESET;
			eq_adjust_q <= `LDC_REG_RESET;
		end else if (rx_commit) begin
			case (rx_addr)
			`LDC_ADDR_CTRL: ctrl_q <= rx_data & `LDC_CTRL_MASK;
			`LDC_ADDR_MOD:  mod_code_q  <= rx_data;
			`LDC_ADDR_BIAS: bias_code_q <= rx_data;
			`LDC_ADDR_EQ:   eq_adjust_q <= rx_data;
			default: begin
				ctrl_q <= ctrl_q;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Enable and fault latch
	// ------------------------------------------------------------

	// Enabled when bit set and pin low; registers untouched either way
	assign active_d = ctrl_q[`LDC_BIT_ENA] & ~disable_pin;
	assign tx_en_d  = active_d & ~fault_flag_pin_q;

	// Latch while enabled; disabling releases it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fault_flag_pin_q <= 1'b0;
		end else if (!active_d) begin
			fault_flag_pin_q <= 1'b0;
		end else if (fault_detected && ctrl_q[`LDC_BIT_FDE]) begin
			fault_flag_pin_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Current setpoints
	// ------------------------------------------------------------

	// Ratio times photodiode step gives bias per code count
	assign closed_mult = ctrl_q[`LDC_BIT_PDR] ?
		16'(`LDC_COUPLING_RATIO * `LDC_PD_STEP_HI) :
		16'(`LDC_COUPLING_RATIO * `LDC_PD_STEP_LO);

	// Modulation and bias targets, zero while not transmitting
	always_comb begin
		mod_d  = 16'h0000;
		bias_d = 16'h0000;
		if (tx_en_d) begin
			if (ctrl_q[`LDC_BIT_MODULATION_RANGE]) begin
				mod_d = 16'(ldc_scale(mod_code_q,
					`LDC_MOD_STEP_HI));
			end else begin
				mod_d = 16'(ldc_scale(mod_code_q,
					`LDC_MOD_STEP_LO));
			end
			if (ctrl_q[`LDC_BIT_OLS]) begin
				bias_d = ldc_clamp(ldc_scale(bias_code_q,
					`LDC_OPEN_STEP));
			end else begin
				bias_d = ldc_clamp(ldc_scale(bias_code_q,
					closed_mult));
			end
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------

	// Mode decode follows the control register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tx_enable_q           <= 1'b0;
			pd_cathode_vcc_q      <= 1'b0;
			pd_range_high_q       <= 1'b0;
			open_loop_select_q    <= 1'b0;
			fault_detect_enable_q <= 1'b0;
			modulation_range_q    <= 1'b0;
		end else begin
			tx_enable_q           <= tx_en_d;
			pd_cathode_vcc_q      <= ctrl_q[`LDC_BIT_PDP];
			pd_range_high_q       <= ctrl_q[`LDC_BIT_PDR];
			open_loop_select_q    <= ctrl_q[`LDC_BIT_OLS];
			fault_detect_enable_q <= ctrl_q[`LDC_BIT_FDE];
			modulation_range_q    <= ctrl_q[`LDC_BIT_MODULATION_RANGE];
		end
	end

	// Equalizer strength is the inverted code, zero when bypassed
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			equalizer_bypass_q <= 1'b0;
			eq_strength_q      <= 8'hFF;
		end else begin
			equalizer_bypass_q <= ctrl_q[`LDC_BIT_EQDIS];
			if (ctrl_q[`LDC_BIT_EQDIS]) begin
				eq_strength_q <= 8'h00;
			end else begin
				eq_strength_q <= ~eq_adjust_q;
			end
		end
	end

	// Current setpoints
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mod_current_ua_q   <= 16'h0000;
			bias_current_hua_q <= 16'h0000;
		end else begin
			mod_current_ua_q   <= mod_d;
			bias_current_hua_q <= bias_d;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	default clocking ck @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	ctrl_write_a: assert property (
		rx_commit && rx_addr == 3'h0 |=> ctrl_q == ($past(rx_data) & 8'hFE))
		else $error("control register did not load");

	mod_write_a: assert property (
		rx_commit && rx_addr == 3'h1 |=> mod_code_q == $past(rx_data))
		else $error("modulation code did not load");

	eq_write_a: assert property (
		rx_commit && rx_addr == 3'h3 |=> eq_adjust_q == $past(rx_data))
		else $error("equalizer code did not load");

	bias_write_a: assert property (
		rx_commit && rx_addr == `LDC_ADDR_BIAS |=>
		bias_code_q == $past(rx_data))
		else $error("bias code did not load");

	unused_addr_a: assert property (
		rx_commit && rx_addr > `LDC_ADDR_EQ |=> $stable(ctrl_q) &&
		$stable(mod_code_q) && $stable(bias_code_q) && $stable(eq_adjust_q))
		else $error("write to unused address changed a register");

	others_hold_a: assert property (
		rx_commit && rx_addr == 3'h1 |=> $stable(ctrl_q) &&
		$stable(bias_code_q) && $stable(eq_adjust_q))
		else $error("unaddressed register changed");

	disable_keep_a: assert property (
		!rx_commit && disable_pin |=> $stable(ctrl_q) && $stable(mod_code_q)
		&& $stable(bias_code_q) && $stable(eq_adjust_q))
		else $error("registers changed without a write");

	fault_clear_a: assert property (
		!ctrl_q[`LDC_BIT_ENA] |=> !fault_flag_pin_q && !tx_enable_q)
		else $error("fault not cleared or transmit while disabled");

	fault_set_a: assert property (
		active_d && fault_detected && ctrl_q[`LDC_BIT_FDE] |=>
		fault_flag_pin_q)
		else $error("fault not latched with detection on");

	fault_gate_a: assert property (
		!fault_flag_pin_q && !ctrl_q[3] |=> !fault_flag_pin_q)
		else $error("fault latched with detection off");

	fault_stop_a: assert property (
		fault_flag_pin_q |=> !tx_enable_q && mod_current_ua_q == 16'h0000)
		else $error("transmit during fault");

	polarity_a: assert property (
		rx_commit && rx_addr == 3'h0 |-> ##2
		pd_cathode_vcc_q == $past(rx_data[6], 2))
		else $error("polarity decode wrong");

	mod_scale_a: assert property (
		tx_en_d && ctrl_q[2] |=> mod_current_ua_q ==
		16'($past(mod_code_q) * 16'h009C))
		else $error("modulation high range scale wrong");

	mod_low_a: assert property (
		tx_en_d && !ctrl_q[`LDC_BIT_MODULATION_RANGE] |=> mod_current_ua_q ==
		16'($past(mod_code_q) * `LDC_MOD_STEP_LO))
		else $error("modulation low range scale wrong");

	open_bias_a: assert property (
		tx_en_d && ctrl_q[4] |=> bias_current_hua_q ==
		16'($past(bias_code_q) * 16'h0096))
		else $error("open-loop bias scale wrong");

	closed_bias_a: assert property (
		tx_en_d && !ctrl_q[`LDC_BIT_OLS] |=> bias_current_hua_q ==
		16'($past(bias_code_q) * `LDC_COUPLING_RATIO *
		($past(ctrl_q[`LDC_BIT_PDR]) ? `LDC_PD_STEP_HI : `LDC_PD_STEP_LO)))
		else $error("closed-loop bias scale wrong");

	bias_cap_a: assert property (
		bias_current_hua_q <= 16'h9C40)
		else $error("bias exceeds ceiling");

	eq_code_a: assert property (
		!ctrl_q[1] |=> eq_strength_q == ~$past(eq_adjust_q))
		else $error("equalizer strength wrong");

	eq_bypass_a: assert property (
		ctrl_q[`LDC_BIT_EQDIS] |=> equalizer_bypass_q &&
		eq_strength_q == 8'h00)
		else $error("equalizer not bypassed");

	ctrl_write_c: cover property (rx_commit && rx_addr == 3'h0);
	fault_set_c: cover property (!fault_flag_pin_q ##1 fault_flag_pin_q);
	fault_rel_c: cover property (fault_flag_pin_q ##1 !fault_flag_pin_q);
	tx_on_c: cover property (tx_enable_q && bias_current_hua_q != 16'h0000);

endmodule
`default_nettype wire

// *** test/ldc_host_model.sv ***
// Host microcontroller model that writes frames over the two-wire link
`timescale 1ns/1ns
`default_nettype none

module ldc_host_model (
	// Clock
	input  wire logic clk_sys,
	// Serial pins, idle high through pull-ups
	output var  logic serial_clk,
	output var  logic serial_data
);
	// Cycles each serial level stands; bench switches prompt and slow
	int hold = 3;

	// Released lines sit at the pull-up level
	initial begin
		serial_clk = 1'b1;
		serial_data = 1'b1;
	end

	// One level change just after an edge, then hold it
	task automatic step(input logic c, input logic d);
		@(posedge clk_sys);
		serial_clk <= c;
		serial_data <= d;
		repeat (hold - 1) @(posedge clk_sys);
	endtask

	// Start, nbits of {addr, data} MSB first, then stop
	task automatic write_frame(input logic [2:0] a, input logic [7:0] d,
			input int nbits);
		logic [10:0] w;
		w = {a, d};
		step(1'b1, 1'b1);
		step(1'b1, 1'b0); // Start: data falls with clock high
		step(1'b0, 1'b0);
		for (int i = 10; i > 10 - nbits; i--) begin
			step(1'b0, w[i]); // Data moves only while clock low
			step(1'b1, w[i]);
			step(1'b0, w[i]);
		end
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1); // Stop: data rises with clock high
	endtask
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the laser driver control register bank
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	// Design pins
	logic        clk_sys;
	logic        rst_b;
	logic        serial_clk;
	logic        serial_data;
	logic        disable_pin;
	logic        fault_detected;
	logic        fault_flag_pin_q;
	logic        tx_enable_q;
	logic        pd_cathode_vcc_q;
	logic        pd_range_high_q;
	logic        open_loop_select_q;
	logic        fault_detect_enable_q;
	logic        modulation_range_q;
	logic        equalizer_bypass_q;
	logic [7:0]  eq_strength_q;
	logic [15:0] mod_current_ua_q;
	logic [15:0] bias_current_hua_q;
	// Expected register contents, fault state and counters
	logic [7:0]  r [4];
	logic        flt_exp;
	int          errors;
	int          cmp_count;
	int          cyc;
	// Ordinary writes, address beside data; every mode bit both ways
	logic [10:0] rows [12] = '{
		{3'h2, 8'h80}, {3'h1, 8'hC8}, {3'h0, 8'h80}, {3'h3, 8'h00},
		{3'h3, 8'hA5}, {3'h0, 8'hA4}, {3'h0, 8'h92}, {3'h2, 8'hFF},
		{3'h1, 8'hFF}, {3'h0, 8'hCD}, {3'h0, 8'h7E}, {3'h0, 8'h98}};

	ldc_host_model u_host (
		.clk_sys     (clk_sys),
		.serial_clk  (serial_clk),
		.serial_data (serial_data)
	);

	ldc_ctrl_regs u_dut (
		.clk_sys               (clk_sys),
		.rst_b                 (rst_b),
		.serial_clk            (serial_clk),
		.serial_data           (serial_data),
		.disable_pin           (disable_pin),
		.fault_detected        (fault_detected),
		.fault_flag_pin_q      (fault_flag_pin_q),
		.tx_enable_q           (tx_enable_q),
		.pd_cathode_vcc_q      (pd_cathode_vcc_q),
		.pd_range_high_q       (pd_range_high_q),
		.open_loop_select_q    (open_loop_select_q),
		.fault_detect_enable_q (fault_detect_enable_q),
		.modulation_range_q    (modulation_range_q),
		.equalizer_bypass_q    (equalizer_bypass_q),
		.eq_strength_q         (eq_strength_q),
		.mod_current_ua_q      (mod_current_ua_q),
		.bias_current_hua_q    (bias_current_hua_q)
	);

	// 250 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// Verdict and end of run
	task automatic results();
		$display("Comparisons %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			results();
		end
	end

	// Compare one flag
	task automatic chk_bit(input string n, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %0h seen %0h", n, e, g);
		end
	endtask

	// Compare one vector
	task automatic chk_vec(input string n, input logic [15:0] e,
			input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %0h seen %0h", n, e, g);
		end
	endtask

	// Send a frame, track what a full frame to a used address stores
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input int n);
		u_host.write_frame(a, d, n);
		if (n == 11 && a < 3'h4) begin
			r[a[1:0]] = (a == 3'h0) ? (d & 8'hFE) : d;
		end
		repeat (5) @(posedge clk_sys);
	endtask

	// Work out every setting from the registers and compare
	task automatic check_all();
		logic        tx;
		logic [15:0] m;
		logic [15:0] b;
		logic [7:0]  eq;
		@(negedge clk_sys);
		tx = r[0][7] & ~disable_pin & ~flt_exp;
		m = {8'h00, r[1]} * (r[0][2] ? 16'h009C : 16'h004E);
		// Half-uA units: open 150, closed 30 times 5 or 1
		b = {8'h00, r[2]} * (r[0][4] ? 16'h0096 :
			(r[0][5] ? 16'h0096 : 16'h001E));
		eq = r[0][1] ? 8'h00 : ~r[3];
		chk_bit("tx_enable", tx, tx_enable_q);
		chk_bit("pd_polarity", r[0][6], pd_cathode_vcc_q);
		chk_bit("pd_range", r[0][5], pd_range_high_q);
		chk_bit("open_loop", r[0][4], open_loop_select_q);
		chk_bit("fault_en", r[0][3], fault_detect_enable_q);
		chk_bit("mod_range", r[0][2], modulation_range_q);
		chk_bit("eq_bypass", r[0][1], equalizer_bypass_q);
		chk_vec("eq_strength", {8'h00, eq}, {8'h00, eq_strength_q});
		chk_vec("mod_current", tx ? m : 16'h0000, mod_current_ua_q);
		chk_vec("bias_current", tx ? b : 16'h0000, bias_current_hua_q);
		chk_bit("fault_flag", flt_exp, fault_flag_pin_q);
	endtask

	// Main sequence
	initial begin
		rst_b = 1'b0;
		disable_pin = 1'b0;
		fault_detected = 1'b0;
		r = '{default: 8'h00};
		flt_exp = 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		// Ordinary writes, alternating prompt and slow host
		for (int i = 0; i < 12; i++) begin
			u_host.hold = (i % 2 == 1) ? 4 : 2;
			wr(rows[i][10:8], rows[i][7:0], 11);
			check_all();
		end
		// Unused address and a short frame leave everything alone
		wr(3'h5, 8'h00, 11);
		check_all();
		wr(3'h2, 8'h00, 10);
		check_all();
		// Disable pin drops the output but keeps the registers
		@(posedge clk_sys);
		disable_pin <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check_all();
		@(posedge clk_sys);
		disable_pin <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check_all();
		// Fault latches, clears through the pin, then through the bit
		@(posedge clk_sys);
		fault_detected <= 1'b1;
		flt_exp = 1'b1;
		repeat (3) @(posedge clk_sys);
		fault_detected <= 1'b0;
		check_all();
		@(posedge clk_sys);
		disable_pin <= 1'b1;
		flt_exp = 1'b0;
		repeat (2) @(posedge clk_sys);
		check_all();
		@(posedge clk_sys);
		disable_pin <= 1'b0;
		fault_detected <= 1'b1;
		flt_exp = 1'b1;
		repeat (3) @(posedge clk_sys);
		fault_detected <= 1'b0;
		check_all();
		wr(3'h0, 8'h18, 11);
		flt_exp = 1'b0;
		check_all();
		wr(3'h0, 8'h98, 11);
		check_all();
		// Detection off ignores the detector
		wr(3'h0, 8'h90, 11);
		@(posedge clk_sys);
		fault_detected <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check_all();
		@(posedge clk_sys);
		fault_detected <= 1'b0;
		// Reset in mid-run clears every register
		@(posedge clk_sys);
		rst_b <= 1'b0;
		r = '{default: 8'h00};
		repeat (2) @(posedge clk_sys);
		check_all();
		@(posedge clk_sys);
		rst_b <= 1'b1;
		wr(3'h0, 8'h80, 11);
		check_all();
		results();
	end
endmodule

`default_nettype wire
